// [rtl/wsg_pkg.sv]
// package: constants and types of the watchdog with stop/wait guard
// What this block does
// - watchdog is a 7-bit low and an 8-bit high stage, counting down.
// - reset or high-stage write loads high with FF and low with 7F.
// - watchdog stays halted after reset until the high stage is written.
// - internal reset fires when high-stage bit 7 becomes zero.
// - after the 2000 ns reset hold the device leaves reset at the reset vector.
// - count freezes in stop mode and resumes once stop is released.
// - count keeps running in wait mode.
// - write to trip is 16.384 ms, or 32.768 ms with mode bit 3 set.
// - count runs in the 2048-cycle stop-release wait; software keeps margin.
// - stop and wait instructions are disabled after reset.
// - enable register changes only on two equal successive writes.
// - stop exits on reset or interrupt; clock returns after release delay on interrupt, at once on reset.
package wsg_pkg;
  localparam int CLK_NS = 25;
  localparam int OSC_NS = 125;
  // low stage source is oscillator/8
  localparam int TICK_NS = 8 * OSC_NS;
  localparam logic [6:0] TICK_CYC = 7'(TICK_NS / CLK_NS);
  localparam logic [6:0] TICK_CYC_SLOW = 7'(2 * TICK_NS / CLK_NS);
  localparam int TRIP_US_FAST = 16384;
  localparam int TRIP_US_SLOW = 32768;
  localparam int TRIP_CYC_FAST = TRIP_US_FAST * 1000 / CLK_NS;
  localparam int TRIP_CYC_SLOW = TRIP_US_SLOW * 1000 / CLK_NS;
  localparam int RELEASE_OSC = 2048;
  localparam int RELEASE_NS = RELEASE_OSC * OSC_NS;
  localparam int RELEASE_CYC = RELEASE_NS / CLK_NS;
  localparam int RST_HOLD_NS = 2000;
  localparam int RST_HOLD_CYC = RST_HOLD_NS / CLK_NS;
  localparam logic [7:0] HIGH_INIT = 8'hFF;
  localparam logic [6:0] LOW_INIT = 7'h7F;
  localparam int HIGH_TRIP_BIT = 7;
  localparam int SWC_STOP_BIT = 0;
  localparam int SWC_WAIT_BIT = 1;
  localparam logic [1:0] SWC_RESET = 2'h0;

  typedef enum logic [1:0] {
    WSG_RUN = 2'b00,
    WSG_STOP = 2'b01,
    WSG_REL = 2'b10,
    WSG_WAIT = 2'b11
  } wsg_mode_t;

  typedef struct packed {
    logic wr;
    logic [1:0] data;
  } wsg_ctl_wr_t;

  typedef struct packed {
    logic stop_en;
    logic wait_en;
    logic stop_mode;
    logic wait_mode;
    logic clk_en;
  } wsg_status_t;

  typedef struct packed {
    wsg_mode_t mode;
    logic armed;
    logic [6:0] low;
    logic [7:0] high;
    logic [1:0] swc;
    logic pend_v;
    logic [1:0] pend;
    logic [6:0] rst_cnt;
    logic in_rst;
    logic vec;
    logic [13:0] rel_cnt;
  } wsg_state_t;

  typedef struct packed {
    logic [6:0] cnt;
  } wsg_tick_state_t;
endpackage

// [rtl/wsg_tick.sv]
// module: low-stage tick prescaler, period chosen by cpu mode bit 3
`timescale 1ns/1ps
module wsg_tick #(
  parameter int TICK_CYCLES = int'(wsg_pkg::TICK_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic slow_in,
  output logic tick_out
);
  wsg_pkg::wsg_tick_state_t q;
  wsg_pkg::wsg_tick_state_t d;
  logic [6:0] last;

  // slow mode doubles the period of the low stage
  assign last = slow_in ? 7'(2 * TICK_CYCLES - 1) : 7'(TICK_CYCLES - 1);
  assign tick_out = run_in && (q.cnt >= last);

  // counter only advances while running, so stop freezes its phase unless a high-stage write clears it
  always_comb
  begin
    d = q;
    if (clear_in)
    begin
      d.cnt = 7'h00;
    end
    else if (run_in)
    begin
      d.cnt = tick_out ? 7'h00 : q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// [rtl/wsg_top.sv]
// module: watchdog timer with guarded stop/wait enables and power-down states
`timescale 1ns/1ps
module wsg_top #(
  parameter int RELEASE_CYCLES = wsg_pkg::RELEASE_CYC,
  // cycles per low-stage tick; only a short-run copy overrides it
  parameter int TICK_CYCLES = int'(wsg_pkg::TICK_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wdh_wr_in,
  input wire wsg_pkg::wsg_ctl_wr_t swc_wr_in,
  input wire logic other_wr_in,
  input wire logic cpu_mode_slow_in,
  input wire logic stop_instruction_in,
  input wire logic wait_instruction_in,
  input wire logic wake_in,
  output logic internal_reset_out,
  output logic vector_fetch_out,
  output logic [7:0] wdg_high_out,
  output wsg_pkg::wsg_status_t status_out
);
  localparam wsg_pkg::wsg_state_t RESET_STATE = '{
    mode: wsg_pkg::WSG_RUN,
    armed: 1'b0,
    low: wsg_pkg::LOW_INIT,
    high: wsg_pkg::HIGH_INIT,
    swc: wsg_pkg::SWC_RESET,
    pend_v: 1'b0,
    pend: 2'h0,
    rst_cnt: 7'h00,
    in_rst: 1'b0,
    vec: 1'b0,
    rel_cnt: 14'h0000
  };

  wsg_pkg::wsg_state_t q;
  wsg_pkg::wsg_state_t d;
  logic run;
  logic tick;
  logic trip;

  // count only when armed, out of reset and not in stop
  assign run = q.armed && !q.in_rst && (q.mode != wsg_pkg::WSG_STOP);
  assign trip = q.armed && !q.in_rst && !q.high[wsg_pkg::HIGH_TRIP_BIT];

  wsg_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(run),
    .clear_in(wdh_wr_in || q.in_rst),
    .slow_in(cpu_mode_slow_in),
    .tick_out(tick)
  );

  // next-state logic; a trip overrides everything else in its cycle
  always_comb
  begin
    d = q;
    d.vec = 1'b0;
    if (q.in_rst)
    begin
      // internal reset holds for RST_HOLD_CYC cycles (2000 ns), then vector fetch
      if (q.rst_cnt == 7'h00)
      begin
        d.in_rst = 1'b0;
        d.vec = 1'b1;
      end
      else
      begin
        d.rst_cnt = q.rst_cnt - 7'h01;
      end
    end
    else
    begin
      // data value of a high-stage write is irrelevant
      if (wdh_wr_in)
      begin
        d.high = wsg_pkg::HIGH_INIT;
        d.low = wsg_pkg::LOW_INIT;
        d.armed = 1'b1;
      end
      else if (tick)
      begin
        // low underflow borrows from the high stage
        if (q.low == 7'h00)
        begin
          d.low = wsg_pkg::LOW_INIT;
          d.high = q.high - 8'h01;
        end
        else
        begin
          d.low = q.low - 7'h01;
        end
      end
      // two equal writes in a row; any other bus write breaks the pair
      if (swc_wr_in.wr)
      begin
        if (q.pend_v && (q.pend == swc_wr_in.data))
        begin
          d.swc = swc_wr_in.data;
          d.pend_v = 1'b0;
        end
        else
        begin
          d.pend_v = 1'b1;
          d.pend = swc_wr_in.data;
        end
      end
      else if (other_wr_in || wdh_wr_in)
      begin
        d.pend_v = 1'b0;
      end
      // power-down sequencing
      case (q.mode)
        wsg_pkg::WSG_RUN:
        begin
          if (stop_instruction_in && q.swc[wsg_pkg::SWC_STOP_BIT])
          begin
            d.mode = wsg_pkg::WSG_STOP;
          end
          else if (wait_instruction_in && q.swc[wsg_pkg::SWC_WAIT_BIT])
          begin
            d.mode = wsg_pkg::WSG_WAIT;
          end
        end
        wsg_pkg::WSG_STOP:
        begin
          if (wake_in)
          begin
            d.mode = wsg_pkg::WSG_REL;
            d.rel_cnt = 14'(RELEASE_CYCLES - 1);
          end
        end
        wsg_pkg::WSG_REL:
        begin
          // oscillator settling; the watchdog keeps counting here
          if (q.rel_cnt == 14'h0000)
          begin
            d.mode = wsg_pkg::WSG_RUN;
          end
          else
          begin
            d.rel_cnt = q.rel_cnt - 14'h0001;
          end
        end
        wsg_pkg::WSG_WAIT:
        begin
          if (wake_in)
          begin
            d.mode = wsg_pkg::WSG_RUN;
          end
        end
        default:
        begin
          d.mode = wsg_pkg::WSG_RUN;
        end
      endcase
      // watchdog reset behaves like a full reset of this block
      if (trip)
      begin
        d = RESET_STATE;
        d.in_rst = 1'b1;
        d.rst_cnt = 7'(wsg_pkg::RST_HOLD_CYC - 1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      q <= RESET_STATE;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from state flops
  assign internal_reset_out = q.in_rst;
  assign vector_fetch_out = q.vec;
  assign wdg_high_out = q.high;
  assign status_out.stop_en = q.swc[wsg_pkg::SWC_STOP_BIT];
  assign status_out.wait_en = q.swc[wsg_pkg::SWC_WAIT_BIT];
  assign status_out.stop_mode = (q.mode == wsg_pkg::WSG_STOP);
  assign status_out.wait_mode = (q.mode == wsg_pkg::WSG_WAIT);
  assign status_out.clk_en = (q.mode == wsg_pkg::WSG_RUN) && !q.in_rst;

  // cycles of running since the last high-stage write, for the trip time
  localparam int AST_HOLD = wsg_pkg::RST_HOLD_CYC;
  localparam int TRIP_FAST = wsg_pkg::TRIP_CYC_FAST / int'(wsg_pkg::TICK_CYC) * TICK_CYCLES;
  localparam int TRIP_SLOW = wsg_pkg::TRIP_CYC_SLOW / int'(wsg_pkg::TICK_CYC) * TICK_CYCLES;
  logic [20:0] run_cyc_q;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      run_cyc_q <= 21'h000000;
    end
    else if (wdh_wr_in)
    begin
      run_cyc_q <= 21'h000001;
    end
    else if (run)
    begin
      run_cyc_q <= run_cyc_q + 21'h000001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence reset_entry;
    $rose(q.in_rst);
  endsequence
  sequence reset_exit;
    !q.in_rst && q.vec;
  endsequence
  sequence pair_done;
    swc_wr_in.wr && q.pend_v && (q.pend == swc_wr_in.data) && !q.in_rst && !trip;
  endsequence

  AST_RELOAD: assert property (wdh_wr_in && !q.in_rst && !trip |=>
    q.high == 8'hFF && q.low == 7'h7F && q.armed)
    else $error("high-stage write did not reload both stages");
  AST_IDLE_UNARMED: assert property (!q.armed |-> q.high == 8'hFF && q.low == 7'h7F)
    else $error("unarmed watchdog moved");
  AST_TRIP: assert property (q.armed && !q.high[7] && !q.in_rst |=> q.in_rst)
    else $error("bit 7 clear did not raise internal reset");
  AST_RELEASE: assert property (reset_entry |-> ##AST_HOLD reset_exit)
    else $error("internal reset release or vector fetch mistimed");
  AST_FREEZE: assert property (q.mode == wsg_pkg::WSG_STOP |=>
    $stable(q.high) && $stable(q.low))
    else $error("watchdog moved in stop mode");
  AST_WAIT_COUNTS: assert property ((q.mode == wsg_pkg::WSG_WAIT ||
    q.mode == wsg_pkg::WSG_REL) && tick && q.low != 7'h00 && !wdh_wr_in && !trip |=>
    q.low == $past(q.low) - 7'h01)
    else $error("watchdog not counting in wait or release");
  AST_TRIP_TIME: assert property ($fell(q.high[7]) |-> run_cyc_q ==
    21'((cpu_mode_slow_in ? TRIP_SLOW : TRIP_FAST) + 1))
    else $error("watchdog trip time wrong");
  AST_UNDERFLOW: assert property (tick && q.low == 7'h00 && !wdh_wr_in && !trip |=>
    q.high == $past(q.high) - 8'h01 && q.low == 7'h7F)
    else $error("low underflow did not step the high stage");
  AST_DISABLED: assert property (q.in_rst |-> q.swc == 2'h0)
    else $error("enables not cleared by reset");
  AST_STOP_GATED: assert property (q.mode == wsg_pkg::WSG_RUN && !q.in_rst &&
    stop_instruction_in && !q.swc[0] && !trip |=> q.mode != wsg_pkg::WSG_STOP)
    else $error("disabled stop instruction took effect");
  AST_PAIR: assert property (pair_done |=> q.swc == $past(swc_wr_in.data))
    else $error("second equal write did not take");
  AST_SINGLE: assert property (swc_wr_in.wr && !q.pend_v && !trip |=> $stable(q.swc))
    else $error("single write changed the enables");
  AST_REL_CLOCK: assert property (q.mode == wsg_pkg::WSG_REL |-> !status_out.clk_en)
    else $error("clock supplied during release wait");
  AST_REL_DONE: assert property (q.mode == wsg_pkg::WSG_REL && q.rel_cnt == 14'h0000 &&
    !trip |=> status_out.clk_en)
    else $error("clock not supplied after release wait");
endmodule

// [tb/tb_top.sv]
// testbench: watchdog count, guarded enables and power-down modes
`timescale 1ns/1ps
module tb_top;
  localparam int REL = 64;
  localparam int LIMIT = 80000;
  typedef struct packed {
    logic [1:0] d1;
    logic [1:0] d2;
    logic brk;
  } wsg_row_t;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic wdh_wr_in = 1'h0;
  wsg_pkg::wsg_ctl_wr_t swc_wr_in = '0;
  logic other_wr_in = 1'h0;
  logic cpu_mode_slow_in = 1'h0;
  logic stop_instruction_in = 1'h0;
  logic wait_instruction_in = 1'h0;
  logic wake_in = 1'h0;
  logic internal_reset_out;
  logic vector_fetch_out;
  logic [7:0] wdg_high_out;
  wsg_pkg::wsg_status_t status_out;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic trip_rst_n = 1'h0;
  logic trip_reset;
  logic trip_vector;
  logic [7:0] trip_high;
  // ticks from a high-stage write to bit 7 clearing
  localparam int TRIP_TICKS = wsg_pkg::TRIP_CYC_FAST / int'(wsg_pkg::TICK_CYC);
  logic [1:0] en_exp = 2'h0;
  // pair table: first data, second data, foreign write between
  wsg_row_t rows [6] = '{'{2'h3, 2'h3, 1'h0}, '{2'h1, 2'h2, 1'h0}, '{2'h0, 2'h0, 1'h0},
    '{2'h1, 2'h1, 1'h1}, '{2'h2, 2'h2, 1'h0}, '{2'h1, 2'h1, 1'h0}};

  wsg_top #(.RELEASE_CYCLES(REL)) dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wdh_wr_in(wdh_wr_in),
    .swc_wr_in(swc_wr_in),
    .other_wr_in(other_wr_in),
    .cpu_mode_slow_in(cpu_mode_slow_in),
    .stop_instruction_in(stop_instruction_in),
    .wait_instruction_in(wait_instruction_in),
    .wake_in(wake_in),
    .internal_reset_out(internal_reset_out),
    .vector_fetch_out(vector_fetch_out),
    .wdg_high_out(wdg_high_out),
    .status_out(status_out)
  );

  // one-cycle tick copy so a real trip fits in the run; held in reset until used
  wsg_top #(.RELEASE_CYCLES(REL), .TICK_CYCLES(1)) dut_trip (
    .clk_in(clk_in),
    .rst_n_in(trip_rst_n),
    .wdh_wr_in(wdh_wr_in),
    .swc_wr_in(swc_wr_in),
    .other_wr_in(other_wr_in),
    .cpu_mode_slow_in(cpu_mode_slow_in),
    .stop_instruction_in(stop_instruction_in),
    .wait_instruction_in(wait_instruction_in),
    .wake_in(wake_in),
    .internal_reset_out(trip_reset),
    .vector_fetch_out(trip_vector),
    .wdg_high_out(trip_high),
    .status_out()
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, about a third above the planned run length
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      $display("unexpected %0t timeout", $time);
      print_verdict();
    end
  end

  // inputs move 2 ns after the edge, outputs are settled then too
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
    #2;
  endtask

  task automatic check_high(input logic [7:0] exp, input string msg);
    total_checks++;
    if (wdg_high_out !== exp)
    begin
      mismatches++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  task automatic check_st(input wsg_pkg::wsg_status_t exp, input string msg);
    total_checks++;
    if (status_out !== exp)
    begin
      mismatches++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask

  function automatic wsg_pkg::wsg_status_t st(input logic [4:0] v);
    st = v;
  endfunction

  task automatic pulse_wdh;
    wdh_wr_in = 1'h1;
    step(1);
    wdh_wr_in = 1'h0;
  endtask

  // one idle cycle after each write so no strobe is set twice in a step
  // apart from the table's foreign-write row, nothing else is written between a pair, as with interrupts masked
  task automatic swc_wr(input logic [1:0] d);
    swc_wr_in = {1'h1, d};
    step(1);
    swc_wr_in = '0;
    step(1);
  endtask

  task automatic instr(input logic stop_instruction);
    if (stop_instruction)
      stop_instruction_in = 1'h1;
    else
      wait_instruction_in = 1'h1;
    step(1);
    stop_instruction_in = 1'h0;
    wait_instruction_in = 1'h0;
  endtask

  // arm, then high must read FF until cycle k-1 and FE at cycle k
  task automatic count_check(input int k);
    pulse_wdh();
    check_high(8'hFF, "load"); // loads FF
    step(k - 2);
    check_high(8'hFF, "early tick");
    step(1);
    check_high(8'hFE, "first high step");
  endtask

  task automatic wake;
    wake_in = 1'h1;
    step(1);
    wake_in = 1'h0;
  endtask

  initial
  begin
    step(10);
    rst_n_in = 1'h1;
    step(1);
    check_st(st(5'h01), "reset status");
    check_high(8'hFF, "reset high");
    check_bit(internal_reset_out, 1'h0, "reset trip");
    check_bit(vector_fetch_out, 1'h0, "reset vector");
    instr(1'h1);
    check_st(st(5'h01), "stop refused");
    step(5200);
    check_high(8'hFF, "unarmed count");
    // double-write table
    foreach (rows[i])
    begin
      swc_wr(rows[i].d1);
      if (rows[i].brk)
      begin
        other_wr_in = 1'h1;
        step(1);
        other_wr_in = 1'h0;
        step(1);
      end
      swc_wr(rows[i].d2);
      if (rows[i].d1 == rows[i].d2 && !rows[i].brk)
        en_exp = rows[i].d1;
      check_st(st({en_exp[0], en_exp[1], 3'h1}), "enable pair");
    end
    count_check(5121);
    step(2000);
    count_check(5121); // rearm mid count
    cpu_mode_slow_in = 1'h1;
    count_check(10241);
    cpu_mode_slow_in = 1'h0;
    instr(1'h0);
    check_st(st(5'h11), "wait refused");
    // stop freezes, release wait keeps counting
    pulse_wdh();
    instr(1'h1);
    check_st(st(5'h14), "stop entry");
    step(6000);
    check_high(8'hFF, "frozen");
    wake();
    check_st(st(5'h10), "release wait");
    step(REL - 1);
    check_bit(status_out.clk_en, 1'h0, "release early");
    step(1);
    check_bit(status_out.clk_en, 1'h1, "release end");
    n = 0;
    while (wdg_high_out !== 8'hFE && n < 5200)
    begin
      step(1);
      n++;
    end
    check_high(8'hFE, "resume");
    // wait mode leaves the count running
    swc_wr(2'h3);
    swc_wr(2'h3);
    pulse_wdh();
    instr(1'h0);
    check_st(st(5'h1A), "wait entry");
    step(5118);
    check_high(8'hFF, "wait early");
    step(1);
    check_high(8'hFE, "wait counting");
    wake();
    check_st(st(5'h19), "wait exit");
    // reset in mid run clears enables and reloads
    rst_n_in = 1'h0;
    step(2);
    check_st(st(5'h01), "mid reset status");
    check_high(8'hFF, "mid reset high");
    rst_n_in = 1'h1;
    step(1);
    check_st(st(5'h01), "after reset");
    // unserviced watchdog trips, holds reset, then fetches the vector
    trip_rst_n = 1'h1;
    step(1);
    pulse_wdh();
    step(TRIP_TICKS - 1);
    check_bit(trip_high[7], 1'h1, "trip early");
    step(1);
    check_bit(trip_high[7], 1'h0, "bit 7 not clear");
    check_bit(trip_reset, 1'h0, "reset too early");
    step(1);
    check_bit(trip_reset, 1'h1, "no internal reset");
    step(wsg_pkg::RST_HOLD_CYC - 1);
    check_bit(trip_reset, 1'h1, "reset too short");
    check_bit(trip_vector, 1'h0, "vector early");
    step(1);
    check_bit(trip_reset, 1'h0, "reset not released");
    check_bit(trip_vector, 1'h1, "no vector fetch");
    check_bit(trip_high == wsg_pkg::HIGH_INIT, 1'h1, "trip reload");
    step(1);
    check_bit(trip_vector, 1'h0, "vector pulse too long");
    print_verdict();
  end
endmodule
